// ---- logic/smdd_top.sv ----
// sector map detect descriptors served over an axi4-lite slave
// How it works
// - in the second detect descriptor a selected bit of one means small sectors at the top.
// - every detect descriptor holds variable address length, variable latency and opcode 65h.
// - the second detect descriptor is a command descriptor and not the last one.
// - the second detect descriptor points at address 00000002h, the first config register.
// - the third detect descriptor masks bit 1, zero for 64 kB and one for 256 kB sectors.
// - the third detect descriptor is flagged as the last detect descriptor.
// - the third detect descriptor points at address 00000004h, the third config register.
// - the map header gives region count minus one as 02h with ones in bits 31:24.
// - the map header carries configuration id 01h for small sectors at the bottom.
// - the map header is a map descriptor and more entries follow it.
// - the second detect descriptor masks bit 2, the top or bottom choice.
// - the three detect bits form id 01h bottom, 03h top or 05h uniform.
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "smdd_consts.svh"
module smdd_top #(
   parameter int ADDR_W = 8
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [7:0] config_id,
   output logic config_legal,
   output logic table_ready
);
   localparam int MAW = 3;

   // word index of an address inside the table
   function automatic logic [MAW-1:0] table_index(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] d;
      d = a - ADDR_W'(`SMDD_OFF_DETECT2_CMD);
      return d[MAW+1:2];
   endfunction

   // register decode shared by read and write paths
   function automatic smdd_pkg::smdd_sel_t decode(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] w;
      w = {a[ADDR_W-1:2], 2'h0};
      if (w >= ADDR_W'(`SMDD_OFF_DETECT2_CMD) && w <= ADDR_W'(`SMDD_OFF_MAP1_HDR)) begin
         return smdd_pkg::SMDD_SEL_TABLE;
      end
      if (w == ADDR_W'(`SMDD_OFF_CR1)) begin
         return smdd_pkg::SMDD_SEL_CR1;
      end
      if (w == ADDR_W'(`SMDD_OFF_CR3)) begin
         return smdd_pkg::SMDD_SEL_CR3;
      end
      if (w == ADDR_W'(`SMDD_OFF_STATUS)) begin
         return smdd_pkg::SMDD_SEL_STATUS;
      end
      if (w == ADDR_W'(`SMDD_OFF_RAR_ADDR)) begin
         return smdd_pkg::SMDD_SEL_RAR_ADDR;
      end
      if (w == ADDR_W'(`SMDD_OFF_RAR_DATA)) begin
         return smdd_pkg::SMDD_SEL_RAR_DATA;
      end
      return smdd_pkg::SMDD_SEL_NONE;
   endfunction

   // detect command descriptor word
   function automatic logic [31:0] detect_cmd(input logic [7:0] mask, input logic last);
      return {mask, `SMDD_ADDR_LEN_VAR, `SMDD_RFU2, `SMDD_LATENCY_VAR,
              `SMDD_INSTR_RAR, `SMDD_RFU6, `SMDD_DESC_CMD, last};
   endfunction

   // table contents in word order
   function automatic logic [31:0] table_word(input logic [MAW-1:0] idx);
      logic [31:0] v;
      v = 32'h00000000;
      unique case (idx)
         3'h0: v = detect_cmd(`SMDD_MASK_TOP_SELECT, `SMDD_DESC_MORE);
         3'h1: v = `SMDD_CR1_ADDR;
         3'h2: v = detect_cmd(`SMDD_MASK_UNIFORM_SIZE, `SMDD_DESC_END);
         3'h3: v = `SMDD_CR3_ADDR;
         3'h4: v = {`SMDD_MAP_RFU, `SMDD_REGION_COUNT_M1, `SMDD_CFG_ID_BOTTOM,
                    `SMDD_RFU6, `SMDD_DESC_MAP, `SMDD_DESC_MORE};
         default: v = 32'h00000000;
      endcase
      return v;
   endfunction

   // byte-lane merge for writable words
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = d[8*i +: 8];
         end
      end
      return r;
   endfunction

   // table loader
   logic [MAW-1:0] load_idx;
   logic mem_we;
   logic [31:0] mem_rdata;

   assign mem_we = !table_ready;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         load_idx <= '0;
         table_ready <= 1'b0;
      end else if (!table_ready) begin
         if (load_idx == `SMDD_TABLE_WORDS - 3'h1) begin
            table_ready <= 1'b1;
         end else begin
            load_idx <= load_idx + 3'h1;
         end
      end
   end

   smdd_mem #(
      .WIDTH(32),
      .DEPTH(8),
      .AW(MAW)
   ) u_mem (
      .sys_clk(sys_clk),
      .reset(reset),
      .we(mem_we),
      .waddr(load_idx),
      .wdata(table_word(load_idx)),
      .raddr(table_index(s_axi_araddr)),
      .rdata(mem_rdata)
   );

   // configuration bytes and read-any-register emulation
   logic [7:0] config_reg_one_nonvolatile;
   logic [7:0] config_reg_three_nonvolatile;
   logic [31:0] rar_addr;
   logic [7:0] rar_data;
   logic [7:0] next_config_id;

   // write channel state
   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic do_write;
   smdd_pkg::smdd_sel_t wr_sel;

   assign do_write = aw_held && w_held && !s_axi_bvalid;
   assign wr_sel = decode(wr_addr);

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s_axi_awready <= 1'b0;
         aw_held <= 1'b0;
         wr_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         aw_held <= 1'b1;
         wr_addr <= s_axi_awaddr;
      end else begin
         if (do_write) begin
            aw_held <= 1'b0;
         end
         s_axi_awready <= !aw_held && !s_axi_bvalid;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s_axi_wready <= 1'b0;
         w_held <= 1'b0;
         wr_data <= '0;
         wr_strb <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         w_held <= 1'b1;
         wr_data <= s_axi_wdata;
         wr_strb <= s_axi_wstrb;
      end else begin
         if (do_write) begin
            w_held <= 1'b0;
         end
         s_axi_wready <= !w_held && !s_axi_bvalid;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SMDD_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         unique case (wr_sel)
            smdd_pkg::SMDD_SEL_CR1, smdd_pkg::SMDD_SEL_CR3,
            smdd_pkg::SMDD_SEL_RAR_ADDR: s_axi_bresp <= `SMDD_RESP_OKAY;
            default: s_axi_bresp <= `SMDD_RESP_SLVERR;
         endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         config_reg_one_nonvolatile <= `SMDD_CR1_RESET;
         config_reg_three_nonvolatile <= `SMDD_CR3_RESET;
         rar_addr <= '0;
      end else if (do_write && wr_strb[0] && wr_sel == smdd_pkg::SMDD_SEL_CR1) begin
         config_reg_one_nonvolatile <= wr_data[7:0];
      end else if (do_write && wr_strb[0] && wr_sel == smdd_pkg::SMDD_SEL_CR3) begin
         config_reg_three_nonvolatile <= wr_data[7:0];
      end else if (do_write && wr_sel == smdd_pkg::SMDD_SEL_RAR_ADDR) begin
         rar_addr <= merge(rar_addr, wr_data, wr_strb);
      end
   end

   // byte returned for the addresses the detect descriptors name
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rar_data <= 8'h00;
      end else if (rar_addr == `SMDD_CR1_ADDR) begin
         rar_data <= config_reg_one_nonvolatile;
      end else if (rar_addr == `SMDD_CR3_ADDR) begin
         rar_data <= config_reg_three_nonvolatile;
      end else begin
         rar_data <= 8'h00;
      end
   end

   // configuration id from the three detect bits
   assign next_config_id = {5'h00,
                            config_reg_three_nonvolatile[`SMDD_CR3_HYBRID_BIT],
                            config_reg_one_nonvolatile[`SMDD_CR1_TOP_BIT],
                            config_reg_three_nonvolatile[`SMDD_CR3_SIZE_BIT]};

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         config_id <= 8'h00;
         config_legal <= 1'b0;
      end else begin
         config_id <= next_config_id;
         config_legal <= next_config_id == `SMDD_CFG_ID_BOTTOM ||
                         next_config_id == `SMDD_CFG_ID_TOP ||
                         next_config_id == `SMDD_CFG_ID_UNIFORM;
      end
   end

   // read channel
   smdd_pkg::smdd_rd_state_t rd_state;
   logic [ADDR_W-1:0] rd_addr;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= rd_state == smdd_pkg::SMDD_RD_IDLE && table_ready;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rd_state <= smdd_pkg::SMDD_RD_IDLE;
         rd_addr <= '0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `SMDD_RESP_OKAY;
      end else begin
         unique case (rd_state)
            smdd_pkg::SMDD_RD_IDLE: begin
               if (s_axi_arvalid && s_axi_arready) begin
                  rd_addr <= s_axi_araddr;
                  rd_state <= smdd_pkg::SMDD_RD_FETCH;
               end
            end
            smdd_pkg::SMDD_RD_FETCH: begin
               s_axi_rvalid <= 1'b1;
               s_axi_rresp <= `SMDD_RESP_OKAY;
               rd_state <= smdd_pkg::SMDD_RD_RESP;
               unique case (decode(rd_addr))
                  smdd_pkg::SMDD_SEL_TABLE: s_axi_rdata <= mem_rdata;
                  smdd_pkg::SMDD_SEL_CR1: s_axi_rdata <= {24'h0, config_reg_one_nonvolatile};
                  smdd_pkg::SMDD_SEL_CR3: s_axi_rdata <= {24'h0, config_reg_three_nonvolatile};
                  smdd_pkg::SMDD_SEL_STATUS: begin
                     s_axi_rdata <= '0;
                     s_axi_rdata[7:0] <= config_id;
                     s_axi_rdata[`SMDD_STAT_LEGAL_BIT] <= config_legal;
                     s_axi_rdata[`SMDD_STAT_READY_BIT] <= table_ready;
                  end
                  smdd_pkg::SMDD_SEL_RAR_ADDR: s_axi_rdata <= rar_addr;
                  smdd_pkg::SMDD_SEL_RAR_DATA: s_axi_rdata <= {24'h0, rar_data};
                  default: begin
                     s_axi_rdata <= '0;
                     s_axi_rresp <= `SMDD_RESP_SLVERR;
                  end
               endcase
            end
            smdd_pkg::SMDD_RD_RESP: begin
               if (s_axi_rready) begin
                  s_axi_rvalid <= 1'b0;
                  rd_state <= smdd_pkg::SMDD_RD_IDLE;
               end
            end
         endcase
      end
   end
endmodule

// ---- logic/smdd_consts.svh ----
// constants for the sector map detect descriptor block
`ifndef SMDD_CONSTS_SVH
`define SMDD_CONSTS_SVH

// byte offsets of the parameter table words
`define SMDD_OFF_DETECT2_CMD 8'h50
`define SMDD_OFF_DETECT2_ADDR 8'h54
`define SMDD_OFF_DETECT3_CMD 8'h58
`define SMDD_OFF_DETECT3_ADDR 8'h5c
`define SMDD_OFF_MAP1_HDR 8'h60
`define SMDD_TABLE_WORDS 3'h5

// byte offsets of the control and status registers
`define SMDD_OFF_CR1 8'h80
`define SMDD_OFF_CR3 8'h84
`define SMDD_OFF_STATUS 8'h88
`define SMDD_OFF_RAR_ADDR 8'h8c
`define SMDD_OFF_RAR_DATA 8'h90

// detect descriptor fields
`define SMDD_ADDR_LEN_VAR 2'h3
`define SMDD_RFU2 2'h3
`define SMDD_LATENCY_VAR 4'hf
`define SMDD_INSTR_RAR 8'h65
`define SMDD_RFU6 6'h3f
`define SMDD_DESC_CMD 1'h0
`define SMDD_DESC_MAP 1'h1
`define SMDD_DESC_MORE 1'h0
`define SMDD_DESC_END 1'h1
`define SMDD_MASK_TOP_SELECT 8'h04
`define SMDD_MASK_UNIFORM_SIZE 8'h02
`define SMDD_CR1_ADDR 32'h00000002
`define SMDD_CR3_ADDR 32'h00000004

// map configuration header fields
`define SMDD_MAP_RFU 8'hff
`define SMDD_REGION_COUNT_M1 8'h02
`define SMDD_CFG_ID_BOTTOM 8'h01
`define SMDD_CFG_ID_TOP 8'h03
`define SMDD_CFG_ID_UNIFORM 8'h05

// bit positions inside the nonvolatile configuration bytes
`define SMDD_CR3_HYBRID_BIT 3
`define SMDD_CR1_TOP_BIT 2
`define SMDD_CR3_SIZE_BIT 1

// reset values
`define SMDD_CR1_RESET 8'h00
`define SMDD_CR3_RESET 8'h02

// status register layout
`define SMDD_STAT_LEGAL_BIT 8
`define SMDD_STAT_READY_BIT 9

// bus responses
`define SMDD_RESP_OKAY 2'h0
`define SMDD_RESP_SLVERR 2'h2

`endif

// ---- logic/smdd_pkg.sv ----
// types for the sector map detect descriptor block
package smdd_pkg;

   typedef enum logic [2:0] {
      SMDD_SEL_TABLE,
      SMDD_SEL_CR1,
      SMDD_SEL_CR3,
      SMDD_SEL_STATUS,
      SMDD_SEL_RAR_ADDR,
      SMDD_SEL_RAR_DATA,
      SMDD_SEL_NONE
   } smdd_sel_t;

   typedef enum logic [1:0] {
      SMDD_RD_IDLE,
      SMDD_RD_FETCH,
      SMDD_RD_RESP
   } smdd_rd_state_t;

endpackage

// ---- logic/smdd_mem.sv ----
// small word memory with registered read data
`timescale 1ns/1ps
module smdd_mem #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8,
   parameter int AW = 3
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [0:DEPTH-1];

   always_ff @(posedge sys_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rdata <= '0;
      end else begin
         rdata <= mem[raddr];
      end
   end
endmodule

// ---- testbench/smdd_top_chk.sv ----
// assertions on the sector map descriptor slave ports
`timescale 1ns/1ps
module smdd_top_chk #(
   parameter int ADDR_W = 8
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic [7:0] config_id,
   input wire logic config_legal
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   logic [8:0] ar;
   logic [32:0] rsp;
   logic aw_go;
   assign ar = {s_axi_arvalid && s_axi_arready, 8'(s_axi_araddr)};
   assign rsp = {s_axi_rvalid, s_axi_rdata};
   assign aw_go = s_axi_awvalid && s_axi_awready;
   det2_word_a: assert property (ar == 9'h150 |-> ##[1:2] rsp == 33'h104ff65fc)
      else $error("detect two word wrong");
   det2_addr_a: assert property (ar == 9'h154 |-> ##[1:2] rsp == 33'h100000002)
      else $error("detect two address wrong");
   det3_word_a: assert property (ar == 9'h158 |-> ##[1:2] rsp == 33'h102ff65fd)
      else $error("detect three word wrong");
   det3_addr_a: assert property (ar == 9'h15c |-> ##[1:2] rsp == 33'h100000004)
      else $error("detect three address wrong");
   map_header_a: assert property (ar == 9'h160 |-> ##[1:2] rsp == 33'h1ff0201fe)
      else $error("map header wrong");
   id_upper_a: assert property (config_id[7:3] == 5'h00)
      else $error("config id upper bits set");
   id_legal_a: assert property ($stable(config_id) |->
      config_legal == (config_id inside {8'h01, 8'h03, 8'h05})) else $error("legal flag wrong");
   table_ro_a: assert property (aw_go && 8'(s_axi_awaddr) inside {[8'h50:8'h63]}
      |-> ##[1:8] s_axi_bvalid && s_axi_bresp == 2'h2) else $error("table write accepted");
endmodule
bind smdd_top smdd_top_chk #(.ADDR_W(ADDR_W)) smdd_top_chk_inst (
   .sys_clk(sys_clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .config_id(config_id), .config_legal(config_legal)
);

// ---- testbench/smdd_host_model.sv ----
// host side model forming the configuration id from detect results
`timescale 1ns/1ps
module smdd_host_model #(
   parameter logic [7:0] DET1_MASK = 8'h08
) (
   input wire logic [31:0] det2_word,
   input wire logic [31:0] det3_word,
   input wire logic [7:0] ret1,
   input wire logic [7:0] ret2,
   input wire logic [7:0] ret3,
   output logic [7:0] host_id
);
   // mask each returned byte, concatenate in descriptor order
   assign host_id = {5'h00, |(ret1 & DET1_MASK), |(ret2 & det2_word[31:24]),
      |(ret3 & det3_word[31:24])};
endmodule

// ---- testbench/tb_top.sv ----
// self-checking bench for the sector map descriptor slave
`timescale 1ns/1ps
`define CHK(what, exp, got) begin \
   compares++; \
   if ((got) !== (exp)) begin \
      miscompares++; \
      $display("wrong value %s expected %h seen %h", what, exp, got); \
   end \
end
module tb_top;
   logic sys_clk = 1'h0;
   logic reset = 1'h1;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'h0;
   logic s_axi_wvalid = 1'h0;
   logic s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0;
   logic s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, det2_word, det3_word;
   logic [7:0] config_id, host_id, ret_cr1, ret_cr3;
   logic config_legal, table_ready;
   int compares = 0;
   int miscompares = 0;
   smdd_top #(.ADDR_W(8)) smdd_top_inst (
      .sys_clk(sys_clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .config_id(config_id),
      .config_legal(config_legal), .table_ready(table_ready)
   );
   smdd_host_model smdd_host_model_inst (
      .det2_word(det2_word), .det3_word(det3_word), .ret1(ret_cr3), .ret2(ret_cr1),
      .ret3(ret_cr3), .host_id(host_id)
   );
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_left;
      logic w_left;
      aw_left = 1'h1;
      w_left = 1'h1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      // each channel released at its own handshake, response taken at its edge
      do begin
         @(posedge sys_clk);
         if (aw_left && s_axi_awready === 1'h1) begin
            aw_left = 1'h0;
            s_axi_awvalid <= 1'h0;
         end
         if (w_left && s_axi_wready === 1'h1) begin
            w_left = 1'h0;
            s_axi_wvalid <= 1'h0;
         end
      end while (aw_left || w_left || s_axi_bvalid !== 1'h1);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
      @(posedge sys_clk);
   endtask
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge sys_clk); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      do @(posedge sys_clk); while (s_axi_rvalid !== 1'h1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
      @(posedge sys_clk);
   endtask
   task automatic finish_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic test_reset_state;
      repeat (8) @(posedge sys_clk);
      `CHK("table ready", 1'h1, table_ready)
      `CHK("reset config id", 8'h01, config_id)
      `CHK("reset legal", 1'h1, config_legal)
   endtask
   task automatic test_descriptors;
      logic [31:0] w [5];
      logic [1:0] r;
      for (int i = 0; i < 5; i++) begin
         axi_read(8'h50 + 8'(4 * i), w[i], r);
         `CHK("read response", 2'h0, r)
      end
      `CHK("detect two mask", 8'h04, w[0][31:24])
      `CHK("detect two fields", 22'h3fd97f, w[0][23:2])
      `CHK("detect three fields", 22'h3fd97f, w[2][23:2])
      `CHK("detect two flags", 2'h0, w[0][1:0])
      `CHK("detect two address", 32'h00000002, w[1])
      `CHK("detect three mask", 8'h02, w[2][31:24])
      `CHK("detect three flags", 2'h1, w[2][1:0])
      `CHK("detect three address", 32'h00000004, w[3])
      `CHK("map count", 16'hff02, w[4][31:16])
      `CHK("map config id", 8'h01, w[4][15:8])
      `CHK("map flags", 2'h2, w[4][1:0])
      det2_word = w[0];
      det3_word = w[2];
   endtask
   task automatic test_read_only;
      logic [31:0] d;
      logic [1:0] r;
      axi_write(8'h50, 32'h0, r);
      `CHK("table write response", 2'h2, r)
      axi_write(8'h60, 32'h0, r);
      `CHK("header write response", 2'h2, r)
      axi_read(8'h50, d, r);
      `CHK("detect two kept", 32'h04ff65fc, d)
      axi_read(8'h60, d, r);
      `CHK("header kept", 32'hff0201fe, d)
      axi_read(8'h40, d, r);
      `CHK("unmapped response", 2'h2, r)
      `CHK("unmapped data", 32'h0, d)
   endtask
   task automatic test_config_detect;
      logic [7:0] cr1 [4] = '{8'h00, 8'h04, 8'h00, 8'h00};
      logic [7:0] cr3 [4] = '{8'h02, 8'h02, 8'h0a, 8'h00};
      logic [7:0] id [4] = '{8'h01, 8'h03, 8'h05, 8'h00};
      logic [31:0] d;
      logic [1:0] r;
      for (int i = 0; i < 4; i++) begin
         axi_write(8'h80, {24'h0, cr1[i]}, r);
         axi_write(8'h84, {24'h0, cr3[i]}, r);
         axi_write(8'h8c, det3_word[31:24] == 8'h02 ? 32'h4 : 32'h0, r);
         axi_read(8'h90, d, r);
         ret_cr3 = d[7:0];
         axi_write(8'h8c, 32'h2, r);
         axi_read(8'h90, d, r);
         ret_cr1 = d[7:0];
         @(posedge sys_clk);
         `CHK("host id", id[i], host_id)
         `CHK("config id", id[i], config_id)
         axi_read(8'h88, d, r);
         `CHK("status", {1'h1, id[i] != 8'h00, id[i]}, d[9:0])
      end
   endtask
   initial begin
      repeat (16) @(posedge sys_clk);
      `CHK("table ready in reset", 1'h0, table_ready)
      reset <= 1'h0;
      test_reset_state();
      test_descriptors();
      test_read_only();
      test_config_detect();
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      finish_test();
   end
endmodule
